// file: dv/dacr_host.sv
// Host software model issuing classic Wishbone single cycles
module dacr_host (
   // Clock
   input  wire logic        clk_i,
   // Wishbone master side
   output logic             wb_cyc_o,
   output logic             wb_stb_o,
   output logic             wb_we_o,
   output logic      [7:0]  wb_adr_o,
   output logic      [3:0]  wb_sel_o,
   output logic      [31:0] wb_dat_o,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic        wb_ack_i
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o  = 1'b0;
      wb_adr_o = 8'h00;
      wb_sel_o = 4'h0;
      wb_dat_o = 32'h0000_0000;
   end
   // Called just after a rising edge; returns one edge after release
   task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w,
                       output logic [31:0] q);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o  <= w;
      wb_adr_o <= a;
      wb_sel_o <= 4'hF;
      wb_dat_o <= d;
      do @(posedge clk_i); while (wb_ack_i !== 1'b1);
      q = wb_dat_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o  <= 1'b0;
      // Released data lines do not keep the last value
      wb_dat_o <= ~d;
      @(posedge clk_i);
   endtask
endmodule // dacr_host

// file: dv/testbench.sv
// Self-checking bench of the acquisition control register bank
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, rst_i = 1'b1;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i, timer_control_o, burst_count_o;
   logic [3:0] wb_sel_i, output_line_o, ext_channel_o, int_channel_o, irq_enable_o;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [3:0] input_line_i = 4'h0, irq_pending_i = 4'h0;
   logic ext_select_i = 1'b0, timer_select_i = 1'b0, ext_trigger_i = 1'b0;
   logic adc_trigger_o, hold_o, user_timer_tick_o, queue_write_o, queue_clear_o;
   logic queue_load_permit_o, post_run_o, about_run_o, count_setup_o, fifo_reset_o;
   logic [1:0] gain_code_o;
   logic [6:0] fn;
   int err_total = 0, checked = 0, n_trig = 0, n_qw = 0, n_qc = 0, n_fr = 0;
   initial forever #2 clk_i = ~clk_i;
   dacr_host host_i (.clk_i, .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i),
      .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i), .wb_dat_i(wb_dat_o),
      .wb_ack_i(wb_ack_o));
   dacr_regs dacr_regs_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .input_line_i, .output_line_o,
      .ext_select_i, .timer_select_i, .ext_trigger_i, .adc_trigger_o, .hold_o,
      .user_timer_tick_o, .timer_control_o, .queue_write_o, .queue_clear_o,
      .ext_channel_o, .int_channel_o, .gain_code_o, .queue_load_permit_o, .burst_count_o,
      .digital_trigger_polarity_o(fn[6]), .external_trigger_polarity_o(fn[5]),
      .burst_sample_hold_o(fn[4]), .burst_mode_select_o(fn[3]), .burst_run_o(fn[2]),
      .post_trigger_select_o(fn[1]), .about_trigger_select_o(fn[0]), .post_run_o,
      .about_run_o, .count_setup_o, .fifo_reset_o, .irq_enable_o, .irq_pending_i);
   // Pulses are counted so a missing or doubled pulse shows up
   always @(posedge clk_i) begin
      if (adc_trigger_o === 1'b1) n_trig++;
      if (queue_write_o === 1'b1) n_qw++;
      if (queue_clear_o === 1'b1) n_qc++;
      if (fifo_reset_o === 1'b1) n_fr++;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (e !== s) begin
         $display("ERROR %s expected %h seen %h", n, e, s);
         err_total++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_i.xfer(a, d, 1'b1, q);
   endtask
   task automatic rd(input logic [7:0] a);
      host_i.xfer(a, 32'h0000_0000, 1'b0, q);
   endtask
   task automatic t_digital;
      input_line_i <= 4'hC;
      wr(8'h1C, 32'h0000_00A5);
      chk("dout", 32'h0000_0005, 32'(output_line_o));
      repeat (5) @(posedge clk_i);
      rd(8'h1C);
      chk("dport", 32'h0000_005C, q);
   endtask
   task automatic t_strobes;
      int t;
      int f;
      t = n_trig;
      f = n_fr;
      wr(8'h20, 32'h0000_0000);
      chk("soft trig", 32'(t + 1), 32'(n_trig));
      wr(8'h34, 32'h0000_00FF);
      chk("fifo rst", 32'(f + 1), 32'(n_fr));
   endtask
   task automatic t_decode;
      wr(8'h0C, 32'h0000_0036);
      chk("tctl", 32'h0000_0036, 32'(timer_control_o));
      rd(8'h0C);
      chk("tctl rd", 32'h0000_0000, q);
      rd(8'h3C);
      chk("unmapped", 32'h0000_0000, q);
      wr(8'h28, 32'h0000_0140);
      chk("burst", 32'h0000_0040, 32'(burst_count_o));
      wr(8'h38, 32'h0000_00F5);
      chk("irq en", 32'h0000_0005, 32'(irq_enable_o));
      irq_pending_i <= 4'hA;
      rd(8'h38);
      chk("irq pend", 32'h0000_000A, q);
   endtask
   task automatic t_queue;
      int w;
      wr(8'h2C, 32'h0000_0001);
      chk("permit", 32'h0000_0001, 32'(queue_load_permit_o));
      for (int g = 0; g < 4; g++) begin
         wr(8'h24, {22'h0, 2'(g), 8'hA7});
         chk("entry", {22'h0, 2'(g), 8'hA7}, {22'h0, gain_code_o, ext_channel_o,
            int_channel_o});
      end
      chk("queued", 32'h0000_0004, 32'(n_qw));
      w = n_qw;
      wr(8'h2C, 32'h0000_0003);
      chk("clear", 32'h0000_0000, 32'(queue_load_permit_o));
      wr(8'h24, 32'h0000_01FF);
      chk("blocked", 32'(w), 32'(n_qw));
      chk("clears", 32'h0000_0001, 32'(n_qc));
   endtask
   task automatic t_function;
      logic [7:0] v [12] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h10, 8'h20,
                             8'h40, 8'h80, 8'h08, 8'h00};
      foreach (v[i]) begin
         wr(8'h30, {24'h0, v[i]});
         chk("func", 32'(v[i][7:1]), 32'(fn));
         chk("trig mode", 32'({v[i][2] & ~v[i][1] & v[i][0], ~v[i][2] & v[i][1] & v[i][0],
            (v[i][2] ^ v[i][1]) & ~v[i][0]}), 32'({post_run_o, about_run_o,
            count_setup_o}));
      end
   endtask
   task automatic t_external;
      int t;
      wr(8'h30, 32'h0000_0040);
      ext_select_i <= 1'b1;
      t = n_trig;
      ext_trigger_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk("ext rise", 32'(t + 1), 32'(n_trig));
      wr(8'h20, 32'h0000_0000);
      chk("soft masked", 32'(t + 1), 32'(n_trig));
      ext_trigger_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk("ext fall", 32'(t + 1), 32'(n_trig));
      ext_select_i <= 1'b0;
   endtask
   task automatic t_timer;
      int c;
      int u;
      int h;
      int t;
      c = 0;
      u = 0;
      h = 0;
      t = 0;
      wr(8'h30, 32'h0000_0010);
      wr(8'h08, 32'h0000_0037);
      rd(8'h08);
      chk("cnt2 held", 32'h0000_0037, q);
      wr(8'h00, 32'h0000_0001);
      wr(8'h04, 32'h0000_0001);
      wr(8'h08, 32'h0000_0002);
      wr(8'h30, 32'h0000_0000);
      timer_select_i <= 1'b1;
      // Any 250 cycles hold exactly four timebase ticks
      repeat (250) begin
         @(posedge clk_i);
         if (user_timer_tick_o === 1'b1) u++;
      end
      chk("user ticks", 32'h0000_0004, 32'(u));
      do @(posedge clk_i); while (adc_trigger_o !== 1'b1);
      do begin
         @(posedge clk_i);
         c++;
      end while (adc_trigger_o !== 1'b1);
      chk("pacer period", 32'h0000_007D, 32'(c));
      wr(8'h08, 32'h0000_0004);
      wr(8'h28, 32'h0000_0002);
      wr(8'h30, 32'h0000_0038);
      do @(posedge clk_i); while (hold_o !== 1'b1);
      // Scan every 250 cycles: hold, one spare tick, then two conversions
      repeat (260) begin
         @(posedge clk_i);
         if (hold_o === 1'b1) h++;
         if (adc_trigger_o === 1'b1) t++;
      end
      chk("holds", 32'h0000_0001, 32'(h));
      chk("burst trigs", 32'h0000_0002, 32'(t));
      timer_select_i <= 1'b0;
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // The whole run takes well under two thousand cycles
   initial begin
      #20000;
      err_total++;
      end_sim;
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_digital;
      t_strobes;
      t_decode;
      t_queue;
      t_function;
      t_external;
      t_timer;
      end_sim;
   end
endmodule // testbench

// file: include/dacr_defines.svh
// Offsets, field positions, reset values and timing counts of the acquisition control bank
`ifndef DACR_DEFINES_SVH
`define DACR_DEFINES_SVH

// Byte offsets on the register bus
`define DACR_OFF_TIMER0      8'h00
`define DACR_OFF_TIMER1      8'h04
`define DACR_OFF_TIMER2      8'h08
`define DACR_OFF_TIMER_CTL   8'h0C
`define DACR_OFF_DIGITAL     8'h1C
`define DACR_OFF_SOFT_TRIG   8'h20
`define DACR_OFF_CHAN_GAIN   8'h24
`define DACR_OFF_BURST_CNT   8'h28
`define DACR_OFF_SCAN_CTL    8'h2C
`define DACR_OFF_FUNCTION    8'h30
`define DACR_OFF_FIFO_RST    8'h34
`define DACR_OFF_IRQ         8'h38

// Scan queue control fields
`define DACR_SCAN_PERMIT_BIT 0
`define DACR_SCAN_CLEAR_BIT  1

// Acquisition function fields
`define DACR_FN_START_BIT    0
`define DACR_FN_ABOUT_BIT    1
`define DACR_FN_POST_BIT     2
`define DACR_FN_RUN_BIT      3
`define DACR_FN_BURST_BIT    4
`define DACR_FN_HOLD_BIT     5
`define DACR_FN_EXTPOL_BIT   6
`define DACR_FN_DIGPOL_BIT   7

// Reset values
`define DACR_RST_BYTE        8'h00
`define DACR_RST_NIBBLE      4'h0
`define DACR_RST_ENTRY       10'h000
`define DACR_RST_WORD        32'h0000_0000

// Timebase: 4 MHz derived from the 250 MHz clock by a phase accumulator
`define DACR_CLK_MHZ         8'hFA
`define DACR_TIMEBASE_MHZ    8'h04

`endif

// file: include/dacr_pkg.sv
// Types shared by the acquisition control bank
`include "dacr_defines.svh"

package dacr_pkg;

   typedef enum logic [1:0] {
      DACR_BURST_IDLE = 2'b00,
      DACR_BURST_HOLD = 2'b01,
      DACR_BURST_CONV = 2'b11
   } dacr_burst_type;

   typedef struct packed {
      logic           ack;
      logic [31:0]    rdata;
      logic [3:0]     output_line;
      logic [7:0]     load0;
      logic [7:0]     load1;
      logic [7:0]     load2;
      logic [7:0]     count0;
      logic [7:0]     count1;
      logic [7:0]     count2;
      logic [7:0]     timer_ctl;
      logic [9:0]     entry;
      logic [7:0]     burst_count;
      logic           queue_load_permit;
      logic [7:0]     func;
      logic [3:0]     irq_enable;
      logic [7:0]     phase;
      logic [3:0]     din_s1;
      logic [3:0]     din_s2;
      logic [3:0]     din_s3;
      logic [3:0]     input_line;
      logic           ext_s1;
      logic           ext_s2;
      logic           ext_s3;
      logic           ext_level;
      dacr_burst_type burst;
      logic [8:0]     burst_left;
      logic           adc_trigger;
      logic           hold;
      logic           queue_write;
      logic           queue_clear;
      logic           fifo_reset;
      logic           user_tick;
   } dacr_state_type;

endpackage

// file: rtl/dacr_regs.sv
// Acquisition control register bank with timer pacing, burst sequencing and digital port

module dacr_regs
   import dacr_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Digital port pins
   input  wire logic [3:0]  input_line_i,
   output logic      [3:0]  output_line_o,
   // Trigger source selection and external trigger pin
   input  wire logic        ext_select_i,
   input  wire logic        timer_select_i,
   input  wire logic        ext_trigger_i,
   // Conversion control
   output logic             adc_trigger_o,
   output logic             hold_o,
   output logic             user_timer_tick_o,
   output logic      [7:0]  timer_control_o,
   // Channel/gain queue
   output logic             queue_write_o,
   output logic             queue_clear_o,
   output logic      [3:0]  ext_channel_o,
   output logic      [3:0]  int_channel_o,
   output logic      [1:0]  gain_code_o,
   output logic             queue_load_permit_o,
   // Acquisition function
   output logic      [7:0]  burst_count_o,
   output logic             digital_trigger_polarity_o,
   output logic             external_trigger_polarity_o,
   output logic             burst_sample_hold_o,
   output logic             burst_mode_select_o,
   output logic             burst_run_o,
   output logic             post_trigger_select_o,
   output logic             about_trigger_select_o,
   output logic             post_run_o,
   output logic             about_run_o,
   output logic             count_setup_o,
   output logic             fifo_reset_o,
   // Interrupt enables and pending flags
   output logic      [3:0]  irq_enable_o,
   input  wire logic [3:0]  irq_pending_i
);

   dacr_state_type st;
   dacr_state_type next_st;

   logic       req_take;
   logic       wr_take;
   logic       rd_take;
   logic [7:0] word_adr;

   assign req_take = wb_cyc_i && wb_stb_i && !st.ack;
   assign wr_take  = req_take && wb_we_i;
   assign rd_take  = req_take && !wb_we_i;
   assign word_adr = {wb_adr_i[7:2], 2'b00};

   always_comb begin
      logic [7:0] tb_sum;
      logic       tb_tick;
      logic       c1_term;
      logic       pacer;
      logic       burst_on;
      logic       burst_stopped;
      logic       timer_trig;
      logic       ext_new;
      logic       ext_edge;
      logic       soft_trig;
      logic [8:0] burst_len;
      tb_sum        = 8'h00;
      tb_tick       = 1'b0;
      c1_term       = 1'b0;
      pacer         = 1'b0;
      burst_on      = 1'b0;
      burst_stopped = 1'b0;
      timer_trig    = 1'b0;
      ext_new       = 1'b0;
      ext_edge      = 1'b0;
      soft_trig     = 1'b0;
      burst_len     = 9'h000;

      next_st             = st;
      next_st.ack         = req_take;
      next_st.adc_trigger = 1'b0;
      next_st.hold        = 1'b0;
      next_st.queue_write = 1'b0;
      next_st.queue_clear = 1'b0;
      next_st.fifo_reset  = 1'b0;
      next_st.user_tick   = 1'b0;

      // Pin synchronisers; a level counts once the second and third stages agree
      next_st.din_s1 = input_line_i;
      next_st.din_s2 = st.din_s1;
      next_st.din_s3 = st.din_s2;
      if (st.din_s2 == st.din_s3) begin
         next_st.input_line = st.din_s3;
      end
      next_st.ext_s1 = ext_trigger_i;
      next_st.ext_s2 = st.ext_s1;
      next_st.ext_s3 = st.ext_s2;
      ext_new = (st.ext_s2 == st.ext_s3) ? st.ext_s3 : st.ext_level;
      next_st.ext_level = ext_new;
      ext_edge = (ext_new != st.ext_level)
                 && (ext_new == st.func[`DACR_FN_EXTPOL_BIT]);
      // Phase accumulator gives an exact 4 MHz average without a fractional divider
      tb_sum = st.phase + `DACR_TIMEBASE_MHZ;
      if (tb_sum >= `DACR_CLK_MHZ) begin
         next_st.phase = tb_sum - `DACR_CLK_MHZ;
         tb_tick       = 1'b1;
      end else begin
         next_st.phase = tb_sum;
      end
      burst_on      = st.func[`DACR_FN_BURST_BIT] && st.func[`DACR_FN_RUN_BIT];
      burst_stopped = st.func[`DACR_FN_BURST_BIT] && !st.func[`DACR_FN_RUN_BIT];
      // User counter runs on its own; a load of zero divides by 256
      if (tb_tick) begin
         if (st.count0 == 8'h01) begin
            next_st.count0    = st.load0;
            next_st.user_tick = 1'b1;
         end else begin
            next_st.count0 = st.count0 - 8'h01;
         end
      end
      // Counters one and two cascade; held at their loads while a burst is set up
      if (burst_stopped) begin
         next_st.count1 = st.load1;
         next_st.count2 = st.load2;
      end else if (tb_tick) begin
         if (st.count1 == 8'h01) begin
            next_st.count1 = st.load1;
            c1_term        = 1'b1;
            if (st.count2 == 8'h01) begin
               next_st.count2 = st.load2;
               pacer          = 1'b1;
            end else begin
               next_st.count2 = st.count2 - 8'h01;
            end
         end else begin
            next_st.count1 = st.count1 - 8'h01;
         end
      end
      // Burst sequencer: one scan per pacer pulse, conversions at the counter one rate
      burst_len = (st.burst_count == 8'h00) ? 9'h100 : {1'b0, st.burst_count};
      if (!st.func[`DACR_FN_BURST_BIT]) begin
         timer_trig    = pacer;
         next_st.burst = DACR_BURST_IDLE;
      end else if (!burst_on) begin
         next_st.burst = DACR_BURST_IDLE;
      end else begin
         case (st.burst)
            DACR_BURST_IDLE: begin
               if (pacer) begin
                  if (st.func[`DACR_FN_HOLD_BIT]) begin
                     next_st.hold       = 1'b1;
                     next_st.burst_left = burst_len;
                     next_st.burst      = DACR_BURST_HOLD;
                  end else begin
                     timer_trig = 1'b1;
                     next_st.burst_left = burst_len - 9'h001;
                     if (burst_len != 9'h001) begin
                        next_st.burst = DACR_BURST_CONV;
                     end
                  end
               end
            end
            DACR_BURST_HOLD: begin
               // The held samples need one extra conversion tick before the scan
               if (c1_term) begin
                  next_st.burst = DACR_BURST_CONV;
               end
            end
            DACR_BURST_CONV: begin
               if (c1_term) begin
                  timer_trig = 1'b1;
                  next_st.burst_left = st.burst_left - 9'h001;
                  if (st.burst_left == 9'h001) begin
                     next_st.burst = DACR_BURST_IDLE;
                  end
               end
            end
            default: begin
               next_st.burst = DACR_BURST_IDLE;
            end
         endcase
      end

      // Bus reads; write-only and unmapped offsets answer zero
      if (rd_take) begin
         case (word_adr)
            `DACR_OFF_TIMER0:  next_st.rdata = {24'h00_0000, st.count0};
            `DACR_OFF_TIMER1:  next_st.rdata = {24'h00_0000, st.count1};
            `DACR_OFF_TIMER2:  next_st.rdata = {24'h00_0000, st.count2};
            `DACR_OFF_DIGITAL: next_st.rdata = {24'h00_0000, st.output_line, st.input_line};
            `DACR_OFF_IRQ:     next_st.rdata = {28'h000_0000, irq_pending_i};
            default:           next_st.rdata = `DACR_RST_WORD;
         endcase
      end

      // Bus writes; strobe offsets act on any write, whatever the data
      if (wr_take) begin
         case (word_adr)
            `DACR_OFF_TIMER0: begin
               if (wb_sel_i[0]) begin
                  next_st.load0  = wb_dat_i[7:0];
                  next_st.count0 = wb_dat_i[7:0];
               end
            end
            `DACR_OFF_TIMER1: begin
               if (wb_sel_i[0]) begin
                  next_st.load1  = wb_dat_i[7:0];
                  next_st.count1 = wb_dat_i[7:0];
               end
            end
            `DACR_OFF_TIMER2: begin
               if (wb_sel_i[0]) begin
                  next_st.load2  = wb_dat_i[7:0];
                  next_st.count2 = wb_dat_i[7:0];
               end
            end
            `DACR_OFF_TIMER_CTL: begin
               if (wb_sel_i[0]) begin
                  next_st.timer_ctl = wb_dat_i[7:0];
               end
            end
            `DACR_OFF_DIGITAL: begin
               if (wb_sel_i[0]) begin
                  next_st.output_line = wb_dat_i[3:0];
               end
            end
            `DACR_OFF_SOFT_TRIG: begin
               soft_trig = 1'b1;
            end
            `DACR_OFF_CHAN_GAIN: begin
               // Blocked writes leave the last entry in place as well
               if (st.queue_load_permit) begin
                  next_st.queue_write = 1'b1;
                  if (wb_sel_i[0]) begin
                     next_st.entry[7:0] = wb_dat_i[7:0];
                  end
                  if (wb_sel_i[1]) begin
                     next_st.entry[9:8] = wb_dat_i[9:8];
                  end
               end
            end
            `DACR_OFF_BURST_CNT: begin
               if (wb_sel_i[0]) begin
                  next_st.burst_count = wb_dat_i[7:0];
               end
            end
            `DACR_OFF_SCAN_CTL: begin
               if (wb_sel_i[0]) begin
                  next_st.queue_clear = wb_dat_i[`DACR_SCAN_CLEAR_BIT];
                  next_st.queue_load_permit = wb_dat_i[`DACR_SCAN_PERMIT_BIT]
                                              && !wb_dat_i[`DACR_SCAN_CLEAR_BIT];
               end
            end
            `DACR_OFF_FUNCTION: begin
               if (wb_sel_i[0]) begin
                  next_st.func = wb_dat_i[7:0];
               end
            end
            `DACR_OFF_FIFO_RST: begin
               next_st.fifo_reset = 1'b1;
            end
            `DACR_OFF_IRQ: begin
               if (wb_sel_i[0]) begin
                  next_st.irq_enable = wb_dat_i[3:0];
               end
            end
            default: next_st.fifo_reset = 1'b0;
         endcase
      end

      // External source masks software and timer triggers
      if (ext_select_i) begin
         next_st.adc_trigger = ext_edge;
      end else begin
         next_st.adc_trigger = soft_trig || (timer_select_i && timer_trig);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign wb_ack_o                    = st.ack;
   assign wb_dat_o                    = st.rdata;
   assign output_line_o               = st.output_line;
   assign adc_trigger_o               = st.adc_trigger;
   assign hold_o                      = st.hold;
   assign user_timer_tick_o           = st.user_tick;
   assign timer_control_o             = st.timer_ctl;
   assign queue_write_o               = st.queue_write;
   assign queue_clear_o               = st.queue_clear;
   assign ext_channel_o               = st.entry[7:4];
   assign int_channel_o               = st.entry[3:0];
   assign gain_code_o                 = st.entry[9:8];
   assign queue_load_permit_o         = st.queue_load_permit;
   assign burst_count_o               = st.burst_count;
   assign digital_trigger_polarity_o  = st.func[`DACR_FN_DIGPOL_BIT];
   assign external_trigger_polarity_o = st.func[`DACR_FN_EXTPOL_BIT];
   assign burst_sample_hold_o         = st.func[`DACR_FN_HOLD_BIT];
   assign burst_mode_select_o         = st.func[`DACR_FN_BURST_BIT];
   assign burst_run_o                 = st.func[`DACR_FN_RUN_BIT];
   assign post_trigger_select_o       = st.func[`DACR_FN_POST_BIT];
   assign about_trigger_select_o      = st.func[`DACR_FN_ABOUT_BIT];
   assign post_run_o    = st.func[`DACR_FN_POST_BIT] && !st.func[`DACR_FN_ABOUT_BIT]
                          && st.func[`DACR_FN_START_BIT];
   assign about_run_o   = st.func[`DACR_FN_ABOUT_BIT] && !st.func[`DACR_FN_POST_BIT]
                          && st.func[`DACR_FN_START_BIT];
   assign count_setup_o = (st.func[`DACR_FN_POST_BIT] ^ st.func[`DACR_FN_ABOUT_BIT])
                          && !st.func[`DACR_FN_START_BIT];
   assign fifo_reset_o                = st.fifo_reset;
   assign irq_enable_o                = st.irq_enable;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_write(logic [7:0] off);
      wr_take && (word_adr == off);
   endsequence
   sequence s_read(logic [7:0] off);
      rd_take && (word_adr == off);
   endsequence
   a_ack_one_cycle: assert property (req_take |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single pulse after request");
   a_dout_latch: assert property (s_write(`DACR_OFF_DIGITAL) and wb_sel_i[0]
      |=> output_line_o == $past(wb_dat_i[3:0]))
      else $error("digital outputs not latched");
   a_dig_read: assert property (s_read(`DACR_OFF_DIGITAL)
      |=> wb_dat_o[7:4] == output_line_o && wb_dat_o[31:8] == 24'h00_0000)
      else $error("digital port readback wrong");
   a_soft_trigger: assert property (s_write(`DACR_OFF_SOFT_TRIG) and !ext_select_i
      |=> adc_trigger_o)
      else $error("software trigger lost");
   a_queue_clear: assert property (s_write(`DACR_OFF_SCAN_CTL) and wb_sel_i[0]
      and wb_dat_i[`DACR_SCAN_CLEAR_BIT] |=> queue_clear_o && !queue_load_permit_o)
      else $error("queue clear not issued");
   a_queue_block: assert property (s_write(`DACR_OFF_CHAN_GAIN) and !queue_load_permit_o
      |=> !queue_write_o)
      else $error("blocked queue write accepted");
   a_fifo_reset: assert property (s_write(`DACR_OFF_FIFO_RST) |=> fifo_reset_o ##1 !fifo_reset_o)
      else $error("fifo reset not a single pulse");
   a_irq_enable: assert property (s_write(`DACR_OFF_IRQ) and wb_sel_i[0]
      |=> irq_enable_o == $past(wb_dat_i[3:0]))
      else $error("interrupt enables not written");
   a_irq_pending: assert property (s_read(`DACR_OFF_IRQ)
      |=> wb_dat_o == {28'h000_0000, $past(irq_pending_i)})
      else $error("pending readback wrong");
   a_ext_masks: assert property (ext_select_i && $past(ext_select_i) && adc_trigger_o
      |-> st.ext_level != $past(st.ext_level))
      else $error("internal trigger while external selected");
   a_post_run: assert property (s_write(`DACR_OFF_FUNCTION) and wb_sel_i[0]
      and wb_dat_i[2:0] == 3'b101 |=> post_run_o && !count_setup_o)
      else $error("post trigger start not decoded");
   a_burst_stop: assert property (burst_mode_select_o && !burst_run_o
      |=> st.burst == DACR_BURST_IDLE && st.count1 == st.load1)
      else $error("burst not held while stopped");

endmodule // dacr_regs
